//--- src/smsc_defines.vh
`ifndef SMSC_DEFINES_VH
`define SMSC_DEFINES_VH

// standby states, binary coded
`define SMSC_ST_RUN 2'h0
`define SMSC_ST_HALT 2'h1
`define SMSC_ST_STOP 2'h2
`define SMSC_ST_SNZ 2'h3
// processor clock source encoding
`define SMSC_SRC_MAIN 1'h0
`define SMSC_SRC_SUB 1'h1
// subsystem source encoding
`define SMSC_SUB_XTAL 1'h0
`define SMSC_SUB_EXT 1'h1
// number of comparators and their bit positions
`define SMSC_NCMP 6
`define SMSC_CMP_ZERO 0
`define SMSC_CMP_TWO 2
// mask of comparators that may run in low-power states
`define SMSC_CMP_LP_MASK 6'h05
// restart delay before the core clock returns, in cycles
`define SMSC_RESTART_CYC 4'h4

`endif

//--- src/smsc_restart_timer.v
`timescale 1ns/10ps
// ==========================================================
// restart timer: counts settle cycles before core clock returns
module smsc_restart_timer #(
    parameter W = 4
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire start,
    input wire [W-1:0] load_val,
    // status
    output reg done
);

reg [W-1:0] cnt_r;
reg busy_r;

// load, count down, flag done for one cycle when the count reaches one
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        cnt_r <= {W{1'b0}};
        busy_r <= 1'b0;
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start)
        begin
            cnt_r <= load_val;
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
            begin
                busy_r <= 1'b0;
                done <= 1'b1;
            end
            else
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule

//--- src/smsc_standby_ctrl.v
`timescale 1ns/10ps
// Summary of operation
// R1: entering halt stops core clock; execution ceases until halt is left
// R2: low-speed osc runs if wake select, else only if watchdog and standby enable
// R3: halt from subsystem keeps used subsystem source, unused one stays off
// R4: halt from subsystem: timers run only while rtc low-power bit is 0
// R5: halt from subsystem disables converter; amplifier may run, output unused
// R6: halt in rtc low-power: comparators zero/two run if enabled, no filter
// R7: halt holds port output latches at pre-halt values
// R8: stop from main clock stops all main sources, keeps subsystem and latches
// R9: converter can wake stop into partial-wake state
// R10: stop: only comparators zero and two, as peripheral select enables
// R11: serial reception or converter trigger enters partial wake; internal osc on
// R12: partial wake keeps subsystem clock and port latches as in stop
// R13: partial wake: comparators zero and two only when stop-cancel enabled
// R14: enabled wake leaves halt or stop, core clock restored before execution
`include "smsc_defines.vh"

module smsc_standby_ctrl #(
    parameter NCMP = `SMSC_NCMP,
    parameter RW = 4
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // standby instructions from the core
    input wire halt_req,
    input wire stop_req,
    input wire cpu_clk_src,
    input wire sub_clk_src,
    // configuration bits
    input wire wake_timer_clock_select,
    input wire watchdog_enable_opt,
    input wire watchdog_standby_enable,
    input wire rtc_low_power_bit,
    input wire [NCMP-1:0] comparator_stop_cancel_enable,
    input wire [NCMP-1:0] cmp_filter_used,
    input wire [NCMP-1:0] cmp_run_en,
    // wake sources
    input wire wake_event,
    input wire clocked_serial_channel_rx,
    input wire async_serial_channel_rx,
    input wire adc_timer_trigger,
    input wire partial_wake_state_done,
    input wire partial_wake_state_to_run,
    // port latch data from the core
    input wire [7:0] port_data,
    // outputs
    output reg cpu_clk_en,
    output reg cpu_run,
    output reg [1:0] state_o,
    output reg high_speed_internal_osc_en,
    output reg main_crystal_clock_en,
    output reg ext_main_clk_en,
    output reg subsystem_crystal_clock_en,
    output reg ext_sub_clk_en,
    output reg low_speed_osc_en,
    output reg timer_en,
    output reg adc_en,
    output reg adc_wake_en,
    output reg gain_amplifier_en,
    output reg [NCMP-1:0] cmp_en,
    output reg port_latch_hold,
    output reg [7:0] port_out
);

// ==========================================================
// state registers
reg [1:0] st_r;
reg [1:0] st_nxt;
reg src_r;      // core clock source captured at standby entry
reg sub_r;      // subsystem source in use at entry
reg main_used_r; // set by reset and in every run cycle; never cleared
reg restarting_r;
wire rst_done;
wire leave_sby; // standby state left at this edge
wire enter_sby; // standby state entered at this edge
wire sub_sel;   // subsystem source that the current halt uses
wire core_ok;   // core clock may be delivered this cycle

// comparators allowed in low-power states: zero/two, cancel enabled, no filter
function [NCMP-1:0] lp_cmp;
    input [NCMP-1:0] sten;
    input [NCMP-1:0] filt;
    begin
        lp_cmp = sten & ~filt & `SMSC_CMP_LP_MASK;
    end
endfunction

// standby to run change; read backwards it gives the run to standby change
function sby_change;
    input [1:0] from_st;
    input [1:0] to_st;
    begin
        sby_change = (from_st != `SMSC_ST_RUN) && (to_st == `SMSC_ST_RUN);
    end
endfunction

// ==========================================================
// next state
always @*
begin
    st_nxt = st_r;
    case (st_r)
        `SMSC_ST_RUN:
        begin
            if (restarting_r)
                st_nxt = st_r;
            else if (stop_req && cpu_clk_src == `SMSC_SRC_MAIN)
                st_nxt = `SMSC_ST_STOP;
            else if (halt_req)
                st_nxt = `SMSC_ST_HALT;
        end
        `SMSC_ST_HALT:
            if (wake_event)
                st_nxt = `SMSC_ST_RUN; // R14
        `SMSC_ST_STOP:
        begin
            // wake beats partial_wake_state triggers when both arrive together
            if (wake_event)
                st_nxt = `SMSC_ST_RUN; // R14
            else if (clocked_serial_channel_rx || async_serial_channel_rx ||
                     adc_timer_trigger)
                st_nxt = `SMSC_ST_SNZ; // R9 R11
        end
        `SMSC_ST_SNZ:
        begin
            if (partial_wake_state_to_run || wake_event)
                st_nxt = `SMSC_ST_RUN;
            else if (partial_wake_state_done)
                st_nxt = `SMSC_ST_STOP;
        end
        default:
            st_nxt = `SMSC_ST_RUN;
    endcase
end

// ==========================================================
// shared decodes
assign leave_sby = sby_change(st_r, st_nxt);
assign enter_sby = sby_change(st_nxt, st_r);
// the pin is read at the entry edge itself, as sub_r only takes it there
assign sub_sel = enter_sby ? sub_clk_src : sub_r;
// gate held through the settle count so no instruction runs on a settling clock
assign core_ok = ~(restarting_r & ~rst_done) & (st_r == `SMSC_ST_RUN);

// restart delay so the core clock is stable before execution resumes
smsc_restart_timer #(
    .W(RW)
) u_restart (
    .clk(clk),
    .rstn(rstn),
    .start(leave_sby),
    .load_val(`SMSC_RESTART_CYC),
    .done(rst_done)
);

// ==========================================================
// state, entry captures and restart flag
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        st_r <= `SMSC_ST_RUN;
        src_r <= `SMSC_SRC_MAIN;
        sub_r <= `SMSC_SUB_XTAL;
        main_used_r <= 1'b1;
        restarting_r <= 1'b0;
    end
    else
    begin
        st_r <= st_nxt;
        // sources captured once; the pins may move while the core sleeps
        if (enter_sby)
        begin
            src_r <= cpu_clk_src;
            sub_r <= sub_clk_src;
        end
        // remember main sources so they come back after stop
        if (st_r == `SMSC_ST_RUN)
            main_used_r <= 1'b1;
        if (leave_sby)
            restarting_r <= 1'b1;
        else if (rst_done)
            restarting_r <= 1'b0;
    end
end

// ==========================================================
// output decode per state, registered
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        cpu_clk_en <= 1'b1;
        cpu_run <= 1'b1;
        state_o <= `SMSC_ST_RUN;
        high_speed_internal_osc_en <= 1'b1;
        main_crystal_clock_en <= 1'b0;
        ext_main_clk_en <= 1'b0;
        subsystem_crystal_clock_en <= 1'b0;
        ext_sub_clk_en <= 1'b0;
        low_speed_osc_en <= 1'b0;
        timer_en <= 1'b1;
        adc_en <= 1'b1;
        adc_wake_en <= 1'b0;
        gain_amplifier_en <= 1'b1;
        cmp_en <= {NCMP{1'b0}};
        port_latch_hold <= 1'b0;
        port_out <= 8'h00;
    end
    else
    begin
        state_o <= st_nxt;
        // low-speed oscillator selection holds in every state
        low_speed_osc_en <= wake_timer_clock_select |
            (watchdog_enable_opt & watchdog_standby_enable); // R2
        // every enable is registered and moves at the edge that takes st_nxt, except cpu_clk_en and cpu_run on leaving standby, which wait for core_ok
        case (st_nxt)
            `SMSC_ST_HALT:
            begin
                cpu_clk_en <= 1'b0; // R1
                cpu_run <= 1'b0; // R1
                port_latch_hold <= 1'b1; // R7
                adc_wake_en <= 1'b0;
                if (src_r == `SMSC_SRC_SUB || cpu_clk_src == `SMSC_SRC_SUB)
                begin
                    high_speed_internal_osc_en <= 1'b0;
                    main_crystal_clock_en <= 1'b0;
                    ext_main_clk_en <= 1'b0;
                    subsystem_crystal_clock_en <= (sub_sel == `SMSC_SUB_XTAL); // R3
                    ext_sub_clk_en <= (sub_sel == `SMSC_SUB_EXT); // R3
                    timer_en <= ~rtc_low_power_bit; // R4
                    adc_en <= 1'b0; // R5
                    gain_amplifier_en <= 1'b1; // R5
                end
                // while src_r and cpu_clk_src both stay main, the oscillators and converter keep their run setting
                else
                    timer_en <= 1'b1;
                // low-power halt: only comparators zero/two, filter off
                if (rtc_low_power_bit)
                    cmp_en <= lp_cmp(comparator_stop_cancel_enable,
                        cmp_filter_used); // R6
                else
                    cmp_en <= cmp_run_en;
            end
            `SMSC_ST_STOP:
            begin
                // subsystem enables left alone: whichever source ran keeps running
                cpu_clk_en <= 1'b0;
                cpu_run <= 1'b0;
                high_speed_internal_osc_en <= 1'b0; // R8
                main_crystal_clock_en <= 1'b0; // R8
                ext_main_clk_en <= 1'b0; // R8
                port_latch_hold <= 1'b1; // R8
                timer_en <= 1'b0;
                adc_en <= 1'b0;
                adc_wake_en <= 1'b1; // R9
                gain_amplifier_en <= 1'b1;
                cmp_en <= lp_cmp(comparator_stop_cancel_enable,
                    cmp_filter_used); // R10
            end
            `SMSC_ST_SNZ:
            begin
                // converter runs on the internal oscillator alone; core stays gated
                cpu_clk_en <= 1'b0;
                cpu_run <= 1'b0;
                high_speed_internal_osc_en <= 1'b1; // R11
                main_crystal_clock_en <= 1'b0; // R11
                ext_main_clk_en <= 1'b0; // R11
                port_latch_hold <= 1'b1; // R12
                timer_en <= 1'b0;
                adc_en <= 1'b1; // R11
                adc_wake_en <= 1'b1;
                gain_amplifier_en <= 1'b1;
                cmp_en <= lp_cmp(comparator_stop_cancel_enable,
                    cmp_filter_used); // R13
            end
            default:
            begin
                // core stays gated until restart delay ends
                cpu_clk_en <= core_ok; // R14
                cpu_run <= core_ok; // R14
                high_speed_internal_osc_en <= 1'b1;
                main_crystal_clock_en <= main_used_r & (cpu_clk_src == `SMSC_SRC_MAIN);
                ext_main_clk_en <= 1'b0;
                subsystem_crystal_clock_en <= (sub_clk_src == `SMSC_SUB_XTAL);
                ext_sub_clk_en <= (sub_clk_src == `SMSC_SUB_EXT);
                timer_en <= 1'b1;
                adc_en <= 1'b1;
                adc_wake_en <= 1'b0;
                gain_amplifier_en <= 1'b1;
                cmp_en <= cmp_run_en;
                port_latch_hold <= 1'b0;
            end
        endcase
        // latches follow the core only while not held; subsystem untouched (R12)
        if (st_nxt == `SMSC_ST_RUN)
            port_out <= port_data;
    end
end

endmodule

//--- verification/smsc_standby_ctrl_chk.sv
`timescale 1ns/10ps
`include "smsc_defines.vh"
// ==========
// port checker for the standby controller
module smsc_standby_ctrl_chk #(
    parameter NCMP = 6
) (
    // clock, reset, requests, settings
    input wire clk, rstn, halt_req, stop_req, wake_event, cpu_clk_src, sub_clk_src,
    input wire wake_timer_clock_select, watchdog_enable_opt, watchdog_standby_enable,
    input wire rtc_low_power_bit, clocked_serial_channel_rx, async_serial_channel_rx,
    input wire adc_timer_trigger,
    input wire [NCMP-1:0] comparator_stop_cancel_enable, cmp_filter_used,
    // watched outputs
    input wire cpu_clk_en, cpu_run, high_speed_internal_osc_en, main_crystal_clock_en,
    input wire ext_main_clk_en, subsystem_crystal_clock_en, ext_sub_clk_en,
    input wire low_speed_osc_en, timer_en, adc_en, adc_wake_en,
    input wire [1:0] state_o,
    input wire [NCMP-1:0] cmp_en,
    input wire [7:0] port_out
);
    // expected oscillator enable, allowed comparators, partial_wake_state triggers
    wire lso_exp = wake_timer_clock_select | (watchdog_enable_opt & watchdog_standby_enable);
    wire [NCMP-1:0] lp_ok = comparator_stop_cancel_enable & `SMSC_CMP_LP_MASK;
    wire trig = clocked_serial_channel_rx | async_serial_channel_rx | adc_timer_trigger;
    wire sub_halt = (state_o == `SMSC_ST_HALT) && cpu_clk_src;
    wire run = state_o == `SMSC_ST_RUN;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // core clock held off four cycles, then back within four more
    sequence s_restart;
        (run && !cpu_clk_en) [*4] ##[1:4] (cpu_clk_en && cpu_run);
    endsequence
    // ==========
    // assertions
    a_halt_core_off: assert property (
        run && cpu_run && halt_req && !stop_req |=> state_o == `SMSC_ST_HALT && !cpu_clk_en)
        else $error("halt entry kept core clock");
    a_low_speed_osc: assert property (
        1'b1 |=> low_speed_osc_en == $past(lso_exp))
        else $error("low-speed oscillator enable wrong");
    a_sub_source_kept: assert property (
        sub_halt && $stable(sub_clk_src) |->
        subsystem_crystal_clock_en == !sub_clk_src && ext_sub_clk_en == sub_clk_src)
        else $error("subsystem source wrong in halt");
    a_timer_rtc_gate: assert property (
        sub_halt && $stable(rtc_low_power_bit) |-> timer_en == !rtc_low_power_bit)
        else $error("timer enable wrong in halt");
    a_adc_off_halt: assert property (sub_halt |-> !adc_en)
        else $error("converter on in subsystem halt");
    a_cmp_halt_lp: assert property (
        state_o == `SMSC_ST_HALT && rtc_low_power_bit && $stable(rtc_low_power_bit)
        |-> (cmp_en & ~(lp_ok & ~cmp_filter_used)) == '0)
        else $error("comparator on in low-power halt");
    a_port_frozen: assert property (
        !run && $past(state_o) != `SMSC_ST_RUN |-> $stable(port_out))
        else $error("port latch moved in standby");
    a_stop_main_off: assert property (
        state_o == `SMSC_ST_STOP |-> !high_speed_internal_osc_en && !main_crystal_clock_en
        && !ext_main_clk_en && adc_wake_en)
        else $error("main source on in stop");
    a_cmp_lp_only: assert property (
        state_o[1] |-> (cmp_en & ~lp_ok) == '0)
        else $error("comparator outside select");
    a_partial_wake_state_entry: assert property (
        state_o == `SMSC_ST_STOP && trig && !wake_event |=> state_o == `SMSC_ST_SNZ
        && high_speed_internal_osc_en && !main_crystal_clock_en && !ext_main_clk_en && adc_en)
        else $error("partial_wake_state entry wrong");
    a_partial_wake_state_sub_kept: assert property (
        state_o == `SMSC_ST_SNZ |-> $stable({subsystem_crystal_clock_en, ext_sub_clk_en}))
        else $error("subsystem clock moved in partial_wake_state");
    a_wake_restart: assert property (
        !run && wake_event |=> s_restart)
        else $error("core restart timing wrong");
endmodule

bind smsc_standby_ctrl smsc_standby_ctrl_chk #(.NCMP(NCMP)) smsc_standby_ctrl_chk_i (.*);

//--- verification/smsc_standby_ctrl_tb_top.sv
`timescale 1ns/10ps
// ==========
// bench for the standby controller
module smsc_standby_ctrl_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [5:0] cfg = 6'h00;
    logic [5:0] comparator_stop_cancel_enable = 6'h3F;
    logic [5:0] cmp_filter_used = 6'h04;
    logic [5:0] cmp_run_en = 6'h3F;
    logic [7:0] port_data = 8'hA5;
    int n_mismatch = 0;
    int tests_run = 0;
    // one pulse bit per request, one level bit per setting
    wire halt_req = ev[0], stop_req = ev[1], wake_event = ev[2];
    wire clocked_serial_channel_rx = ev[3], async_serial_channel_rx = ev[4];
    wire adc_timer_trigger = ev[5], partial_wake_state_done = ev[6], partial_wake_state_to_run = ev[7];
    wire wake_timer_clock_select = cfg[0], watchdog_enable_opt = cfg[1];
    wire watchdog_standby_enable = cfg[2], rtc_low_power_bit = cfg[3];
    wire cpu_clk_src = cfg[4], sub_clk_src = cfg[5];
    // outputs, and grouped views so each compare fits one line
    wire cpu_clk_en, cpu_run, high_speed_internal_osc_en, main_crystal_clock_en;
    wire ext_main_clk_en, subsystem_crystal_clock_en, ext_sub_clk_en, low_speed_osc_en;
    wire timer_en, adc_en, adc_wake_en, gain_amplifier_en, port_latch_hold;
    wire [1:0] state_o;
    wire [5:0] cmp_en;
    wire [7:0] port_out;
    wire [7:0] core_v = {3'h0, port_latch_hold, cpu_clk_en, cpu_run, state_o};
    wire [7:0] sub_v = {2'h0, subsystem_crystal_clock_en, ext_sub_clk_en,
        timer_en, adc_en, state_o};
    wire [7:0] main_v = {1'h0, high_speed_internal_osc_en, main_crystal_clock_en,
        ext_main_clk_en, adc_wake_en, adc_en, state_o};

    smsc_standby_ctrl smsc_standby_ctrl_i (.*);

    always #5 clk = ~clk;
    // hang guard, far above the fewer than 200 cycles the tests need
    initial
    begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle request; outputs read once the taking edge has landed
    task automatic pulse(input int b);
        @(posedge clk);
        ev <= 8'h01 << b;
        @(posedge clk);
        ev <= 8'h00;
        #1;
    endtask
    // bounded wait for the core to run again after a wake
    task automatic wait_run;
        for (int i = 0; i < 12 && cpu_run !== 1'b1; i++)
            @(posedge clk) #1;
        chk("cpu_run", 8'h01, {7'h0, cpu_run});
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk) #1;
        chk("reset", 8'h0C, core_v);
        // low-speed oscillator over every select combination
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            cfg <= 6'(i);
            repeat (2) @(posedge clk);
            #1;
            chk("lso", {7'h0, i[0] | (i[1] & i[2])}, {7'h0, low_speed_osc_en});
        end
        $display("test oscillator done");
        // halt from main clock, halt refused during the restart delay
        pulse(0);
        @(posedge clk);
        port_data <= 8'h3C;
        repeat (2) @(posedge clk);
        #1;
        chk("halt", 8'h11, core_v);
        chk("port", 8'hA5, port_out);
        pulse(2);
        chk("wake", 8'h00, core_v);
        pulse(0);
        chk("halt refused", 8'h00, core_v);
        wait_run();
        @(posedge clk) #1;
        chk("port", 8'h3C, port_out);
        $display("test halt done");
        // halt from subsystem, both sources, both low-power settings
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            cfg <= {s[0], 1'b1, s[1], 3'h0};
            pulse(1);
            chk("stop refused", 8'h0C, core_v);
            pulse(0);
            chk("halt sub", {2'h0, ~s[0], s[0], ~s[1], 3'h1}, sub_v);
            chk("halt cmp", s[1] ? 8'h01 : 8'h3F, {2'h0, cmp_en});
            chk("halt pga", 8'h01, {7'h0, gain_amplifier_en});
            pulse(2);
            wait_run();
        end
        $display("test subsystem halt done");
        // stop, each partial_wake_state trigger, each way out
        @(posedge clk);
        cfg <= 6'h00;
        for (int t = 0; t < 3; t++)
        begin
            pulse(1);
            chk("stop", 8'h0A, main_v & 8'hFB);
            chk("stop cmp", 8'h00, {2'h0, cmp_en & 6'h3A});
            pulse(3 + t);
            chk("partial_wake_state", 8'h47, main_v & 8'hF7);
            chk("partial_wake_state cmp", 8'h00, {2'h0, cmp_en & 6'h3A});
            if (t == 0)
                pulse(6);
            pulse(t == 1 ? 7 : 2);
            wait_run();
        end
        $display("test stop done");
        conclude();
    end
endmodule
